// *** rtl/mid_dec_if.sv ***
`timescale 1ns/1ns
interface mid_dec_if;
  import mid_pkg::*;
  logic [15:0] word1;
  logic [15:0] word2;
  mid_cls_t cls;
  logic [7:0] f8;
  logic to_file;
  logic acc_bank;
  logic [2:0] bit_idx;
  logic [7:0] k8;
  logic [11:0] k12;
  logic [19:0] k20;
  logic [11:0] move_source_address;
  logic [11:0] move_target_address;
  logic [PC_W-1:0] rel_off;
  logic fast;
  logic [1:0] pointer_step_mode;
  logic second_ok;
  modport dec (
    input word1, word2,
    output cls, f8, to_file, acc_bank, bit_idx, k8, k12, k20, move_source_address,
    output move_target_address, rel_off, fast, pointer_step_mode, second_ok
  );
  modport seq (
    output word1, word2,
    input cls, f8, to_file, acc_bank, bit_idx, k8, k12, k20, move_source_address,
    input move_target_address, rel_off, fast, pointer_step_mode, second_ok
  );
endinterface

// *** rtl/mid_decoder.sv ***
`timescale 1ns/1ns
module mid_decoder
  import mid_pkg::*;
(
  mid_dec_if.dec d
);
  // the class codes are checked in priority order, most specific first
  always_comb
  begin
    casez (d.word1)
      16'b1111_????_????_????: d.cls = CLS_NOP; // [RULE3]
      16'b1100_????_????_????: d.cls = CLS_MOVE; // [RULE2]
      16'b1110_1111_????_????: d.cls = CLS_GOTO; // [RULE2]
      16'b1110_110?_????_????: d.cls = CLS_CALL; // [RULE2]
      16'b1110_1110_00??_????: d.cls = CLS_LPTR; // [RULE2]
      16'b1101_0???_????_????: d.cls = CLS_BRA;
      16'b1101_1???_????_????: d.cls = CLS_RCALL;
      16'b1110_0???_????_????: d.cls = CLS_BCOND;
      16'b101?_????_????_????: d.cls = CLS_BITSKIP;
      16'b100?_????_????_????: d.cls = CLS_BIT;
      16'b0110_0???_????_????: d.cls = CLS_BYTESKIP;
      16'b0000_0000_0001_001?: d.cls = CLS_RET;
      16'b0000_0000_0000_10??: d.cls = CLS_TBLRD;
      16'b0000_0000_0000_11??: d.cls = CLS_TBLWR;
      16'b0000_1???_????_????: d.cls = CLS_LIT;
      16'b0000_????_????_????: d.cls = CLS_NOP;
      default: d.cls = CLS_BYTE; // [RULE1]
    endcase
  end

  assign d.f8 = d.word1[7:0]; // [RULE10]
  assign d.to_file = d.word1[9]; // [RULE7]
  assign d.acc_bank = d.word1[8]; // [RULE8]
  assign d.bit_idx = d.word1[11:9]; // [RULE9]
  assign d.k8 = d.word1[7:0]; // [RULE12]
  assign d.k12 = {d.word1[3:0], d.word2[7:0]}; // [RULE12]
  assign d.k20 = {d.word2[11:0], d.word1[7:0]}; // [RULE20]
  assign d.move_source_address = d.word1[11:0]; // [RULE11]
  assign d.move_target_address = d.word2[11:0]; // [RULE11]
  // call keeps its fast bit just above the low target byte, return keeps it in bit 0
  assign d.fast = (d.cls == CLS_CALL) ? d.word1[8] : d.word1[0]; // [RULE18]
  assign d.pointer_step_mode = d.word1[1:0]; // [RULE13]
  assign d.second_ok = (d.word2[15:12] == SECOND_WORD_TAG); // [RULE3]

  // relative offsets are signed word counts, doubled to byte distance
  always_comb
  begin
    if (d.cls == CLS_BCOND)
      d.rel_off = {{12{d.word1[7]}}, d.word1[7:0], 1'b0}; // [RULE14]
    else
      d.rel_off = {{9{d.word1[10]}}, d.word1[10:0], 1'b0}; // [RULE14]
  end
endmodule

// *** rtl/mid_instr_seq.sv ***
`timescale 1ns/1ns
// Function
// (RULE1) ordinary instruction: one 16-bit opcode word
// (RULE2) three instructions span two program words; the decoder treats four as two-word: move, goto, call, lptr
// (RULE3) second word tagged 1111 runs as no-op
// (RULE4) single word: one cycle, two when taken
// (RULE5) double-word instructions take two cycles
// (RULE6) instruction cycle is four oscillator periods
// (RULE7) destination bit 0 working register, 1 file
// (RULE8) access bit 0 access RAM, 1 bank select
// (RULE9) three-bit index picks bit 0 to 7
// (RULE10) file field is 8-bit address 00 to FF
// (RULE11) move carries 12-bit source and target
// (RULE12) literals are 8, 12 or 20 bits
// (RULE13) table mode: none, post-inc, post-dec, pre-inc
// (RULE14) relative offsets signed; call/goto absolute
// (RULE15) every file access reads before writing; move writes its target without reading it first
// (RULE16) that read causes port read side effects
// (RULE17) bit index with file field selects bit
// (RULE18) fast bit 1 uses shadows, 0 untouched
// (RULE19) 21-bit table pointer, 8-bit table latch
// (RULE20) absolute target: 8 low, 12 high bits
// (RULE21) changed counter discards prefetched word
module mid_instr_seq
  import mid_pkg::*;
(
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  // axi4-lite register slave
  input wire logic [AXI_AW-1:0] i_s_axi_awaddr,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  output logic [1:0] o_s_axi_bresp,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic [AXI_AW-1:0] i_s_axi_araddr,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  // program memory
  output logic [PC_W-1:0] o_pm_addr,
  input wire logic [15:0] i_pm_word,
  // condition result and stack
  input wire logic i_cond_true,
  input wire logic [PC_W-1:0] i_tos,
  output logic o_stack_push,
  output logic o_stack_pop,
  output logic [PC_W-1:0] o_ret_addr,
  output logic o_shadow_save,
  output logic o_shadow_restore,
  // file register access
  output logic [FA_W-1:0] o_file_addr,
  output logic o_file_rd,
  output logic o_file_wr,
  output logic o_to_working_register,
  output logic o_bit_op,
  output logic [2:0] o_bit_idx,
  output logic [19:0] o_literal,
  output logic o_lit_valid,
  // table access
  output logic [PC_W-1:0] o_tbl_addr,
  output logic o_tbl_rd,
  output logic o_tbl_wr,
  output logic [7:0] o_tbl_wdata,
  input wire logic [7:0] i_tbl_rdata
);
  function automatic logic [PC_W-1:0] pc_add(input logic [PC_W-1:0] a,
                                             input logic [PC_W-1:0] b);
    pc_add = a + b;
  endfunction

  mid_dec_if dec_bus ();
  mid_q_t q;
  logic run;
  logic [3:0] bank_select_register;
  logic [PC_W-1:0] table_pointer;
  logic [7:0] table_latch;
  logic [PC_W-1:0] pc;
  logic [PC_W-1:0] pre_pc;
  logic [PC_W-1:0] exec_pc;
  logic [15:0] exec_word;
  logic [15:0] pre_word;
  logic flush;
  logic move_pend;
  logic [FA_W-1:0] move_dst;
  logic [31:0] icount;
  logic in_q1;
  logic in_q2;
  logic in_q3;
  logic in_q4;
  logic take_jump;
  logic skip_take;
  logic file_cls;
  logic [PC_W-1:0] jump_target;
  logic [FA_W-1:0] eff_addr;
  logic [PC_W-1:0] next_tptr;
  logic [PC_W-1:0] tbl_access;
  logic aw_held;
  logic w_held;
  logic [AXI_AW-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  logic sw_tptr_wr;
  logic sw_tlat_wr;

  assign dec_bus.word1 = exec_word;
  assign dec_bus.word2 = pre_word;

  mid_decoder u_decoder (
    .d(dec_bus.dec)
  );

  // four-phase sequencer; it freezes while run is clear
  always_ff @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      q <= Q1;
    else if (run)
    begin
      case (q)
        Q1: q <= Q2; // [RULE6]
        Q2: q <= Q3;
        Q3: q <= Q4;
        Q4: q <= Q1;
        default: q <= Q1;
      endcase
    end
  end

  assign in_q1 = run && (q == Q1);
  assign in_q2 = run && (q == Q2);
  assign in_q3 = run && (q == Q3);
  assign in_q4 = run && (q == Q4);

  assign file_cls = (dec_bus.cls == CLS_BYTE) || (dec_bus.cls == CLS_BYTESKIP) ||
                    (dec_bus.cls == CLS_BIT) || (dec_bus.cls == CLS_BITSKIP);
  assign eff_addr = {(dec_bus.acc_bank ? bank_select_register : ACCESS_BANK),
                     dec_bus.f8}; // [RULE8] [RULE10]
  assign skip_take = ((dec_bus.cls == CLS_BYTESKIP) || (dec_bus.cls == CLS_BITSKIP)) &&
                     i_cond_true; // [RULE4]

  always_comb
  begin
    case (dec_bus.cls)
      CLS_GOTO, CLS_CALL, CLS_BRA, CLS_RCALL, CLS_RET: take_jump = 1'b1;
      CLS_BCOND: take_jump = i_cond_true; // [RULE4]
      default: take_jump = 1'b0;
    endcase
    case (dec_bus.cls)
      CLS_GOTO, CLS_CALL: jump_target = {dec_bus.k20, 1'b0}; // [RULE14] [RULE20]
      CLS_RET: jump_target = i_tos;
      default: jump_target = pc_add(pc_add(exec_pc, PC_STEP), dec_bus.rel_off); // [RULE14]
    endcase
  end

  // fetch pipeline: the counter moves in Q2 so Q4 already fetches the target
  always_ff @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      pc <= '0;
      pre_pc <= '0;
      exec_pc <= '0;
      pre_word <= NOP_WORD;
      exec_word <= NOP_WORD;
      flush <= 1'b0;
    end
    else if (in_q2 && (take_jump || skip_take))
    begin
      flush <= 1'b1; // [RULE21]
      if (take_jump)
        pc <= jump_target;
    end
    else if (in_q4)
    begin
      // a double-word second word lands in exec and runs as a no-op
      exec_word <= flush ? NOP_WORD : pre_word; // [RULE21] [RULE4] [RULE5] [RULE3]
      exec_pc <= pre_pc;
      pre_word <= i_pm_word;
      pre_pc <= pc;
      pc <= pc_add(pc, PC_STEP);
      flush <= 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      icount <= '0;
    else if (in_q4)
      icount <= icount + 32'h1;
  end

  // file register port: read in Q1, write back in Q3
  always_ff @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_file_addr <= '0;
      o_file_rd <= 1'b0;
      o_file_wr <= 1'b0;
      o_to_working_register <= 1'b0;
      o_bit_op <= 1'b0;
      o_bit_idx <= '0;
      move_pend <= 1'b0;
      move_dst <= '0;
    end
    else
    begin
      o_file_rd <= 1'b0;
      o_file_wr <= 1'b0;
      o_to_working_register <= 1'b0;
      if (in_q1 && file_cls)
      begin
        // the read is issued even for write-only forms so ports see it
        o_file_addr <= eff_addr; // [RULE15] [RULE16] [RULE17]
        o_file_rd <= 1'b1; // [RULE15] [RULE16]
        o_bit_op <= (dec_bus.cls == CLS_BIT) || (dec_bus.cls == CLS_BITSKIP);
        o_bit_idx <= dec_bus.bit_idx; // [RULE9] [RULE17]
      end
      else if (in_q1 && (dec_bus.cls == CLS_MOVE))
      begin
        o_file_addr <= dec_bus.move_source_address; // [RULE11]
        o_file_rd <= 1'b1; // [RULE15]
        o_bit_op <= 1'b0;
        move_pend <= 1'b1;
        move_dst <= dec_bus.move_target_address; // [RULE11]
      end
      else if (in_q3 && move_pend)
      begin
        o_file_addr <= move_dst;
        o_file_wr <= 1'b1;
        move_pend <= 1'b0;
      end
      else if (in_q3 && (dec_bus.cls == CLS_BYTE))
      begin
        o_file_wr <= dec_bus.to_file; // [RULE7]
        o_to_working_register <= !dec_bus.to_file; // [RULE7]
      end
      else if (in_q3 && (dec_bus.cls == CLS_BIT))
        o_file_wr <= 1'b1; // [RULE15]
      else if (in_q3 && (dec_bus.cls == CLS_LIT))
        o_to_working_register <= 1'b1;
    end
  end

  // literal operand capture
  always_ff @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_literal <= '0;
      o_lit_valid <= 1'b0;
    end
    else
    begin
      o_lit_valid <= 1'b0;
      if (in_q1 && (dec_bus.cls == CLS_LIT))
      begin
        o_literal <= {12'h000, dec_bus.k8}; // [RULE12]
        o_lit_valid <= 1'b1;
      end
      else if (in_q1 && (dec_bus.cls == CLS_LPTR) && dec_bus.second_ok)
      begin
        o_literal <= {8'h00, dec_bus.k12}; // [RULE12]
        o_lit_valid <= 1'b1;
      end
      else if (in_q1 && (dec_bus.cls == CLS_GOTO || dec_bus.cls == CLS_CALL))
      begin
        o_literal <= dec_bus.k20; // [RULE12] [RULE20]
        o_lit_valid <= 1'b1;
      end
    end
  end

  // call and return: stack and shadow strobes in Q2
  always_ff @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_stack_push <= 1'b0;
      o_stack_pop <= 1'b0;
      o_ret_addr <= '0;
      o_shadow_save <= 1'b0;
      o_shadow_restore <= 1'b0;
    end
    else
    begin
      o_stack_push <= in_q2 && (dec_bus.cls == CLS_CALL || dec_bus.cls == CLS_RCALL);
      o_stack_pop <= in_q2 && (dec_bus.cls == CLS_RET);
      o_shadow_save <= in_q2 && (dec_bus.cls == CLS_CALL) && dec_bus.fast; // [RULE18]
      o_shadow_restore <= in_q2 && (dec_bus.cls == CLS_RET) && dec_bus.fast; // [RULE18]
      if (in_q2)
        o_ret_addr <= (dec_bus.cls == CLS_CALL) ? pc : pre_pc;
    end
  end

  // table access: pointer stepped in Q3, latch loaded in Q4
  always_comb
  begin
    case (dec_bus.pointer_step_mode)
      MM_POST_INC: next_tptr = pc_add(table_pointer, TPTR_STEP); // [RULE13]
      MM_POST_DEC: next_tptr = table_pointer - TPTR_STEP; // [RULE13]
      MM_PRE_INC: next_tptr = pc_add(table_pointer, TPTR_STEP); // [RULE13]
      default: next_tptr = table_pointer; // [RULE13]
    endcase
    tbl_access = (dec_bus.pointer_step_mode == MM_PRE_INC) ? next_tptr : table_pointer;
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      table_pointer <= '0;
      o_tbl_addr <= '0;
      o_tbl_rd <= 1'b0;
      o_tbl_wr <= 1'b0;
      o_tbl_wdata <= '0;
    end
    else
    begin
      o_tbl_rd <= in_q3 && (dec_bus.cls == CLS_TBLRD);
      o_tbl_wr <= in_q3 && (dec_bus.cls == CLS_TBLWR);
      if (in_q3 && (dec_bus.cls == CLS_TBLRD || dec_bus.cls == CLS_TBLWR))
      begin
        o_tbl_addr <= tbl_access; // [RULE19]
        o_tbl_wdata <= table_latch; // [RULE19]
      end
      // a software write in the same cycle as a step takes priority
      if (sw_tptr_wr)
        table_pointer <= w_data[PC_W-1:0]; // [RULE19]
      else if (in_q3 && (dec_bus.cls == CLS_TBLRD || dec_bus.cls == CLS_TBLWR))
        table_pointer <= next_tptr; // [RULE13]
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      table_latch <= '0;
    else if (in_q4 && (dec_bus.cls == CLS_TBLRD))
      table_latch <= i_tbl_rdata; // [RULE19]
    else if (sw_tlat_wr && w_strb[0])
      table_latch <= w_data[7:0];
  end

  // axi4-lite write: address and data taken in either order
  assign wr_fire = aw_held && w_held && !o_s_axi_bvalid;
  assign sw_tptr_wr = wr_fire && (aw_addr == REG_TPTR) && (&w_strb[2:0]);
  assign sw_tlat_wr = wr_fire && (aw_addr == REG_TLAT);

  always_ff @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      o_s_axi_awready <= 1'b0;
      o_s_axi_wready <= 1'b0;
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp <= RESP_OKAY;
    end
    else
    begin
      o_s_axi_awready <= !aw_held && !o_s_axi_awready;
      o_s_axi_wready <= !w_held && !o_s_axi_wready;
      if (i_s_axi_awvalid && o_s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= i_s_axi_awaddr;
        o_s_axi_awready <= 1'b0;
      end
      if (i_s_axi_wvalid && o_s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= i_s_axi_wdata;
        w_strb <= i_s_axi_wstrb;
        o_s_axi_wready <= 1'b0;
      end
      if (wr_fire)
      begin
        o_s_axi_bvalid <= 1'b1;
        case (aw_addr)
          REG_CTRL, REG_BANK, REG_TPTR, REG_TLAT, REG_PC, REG_IWORD, REG_ICOUNT:
            o_s_axi_bresp <= RESP_OKAY;
          default: o_s_axi_bresp <= RESP_SLVERR;
        endcase
      end
      else if (o_s_axi_bvalid && i_s_axi_bready)
      begin
        o_s_axi_bvalid <= 1'b0;
        aw_held <= 1'b0;
        w_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      run <= 1'b0;
      bank_select_register <= '0;
    end
    else if (wr_fire && w_strb[0])
    begin
      if (aw_addr == REG_CTRL)
        run <= w_data[CTRL_RUN_BIT];
      if (aw_addr == REG_BANK)
        bank_select_register <= w_data[3:0]; // [RULE8]
    end
  end

  // axi4-lite read: one outstanding, data one cycle after address
  always_ff @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_s_axi_arready <= 1'b0;
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_rdata <= '0;
      o_s_axi_rresp <= RESP_OKAY;
    end
    else
    begin
      o_s_axi_arready <= !o_s_axi_rvalid && !o_s_axi_arready;
      if (i_s_axi_arvalid && o_s_axi_arready)
      begin
        o_s_axi_arready <= 1'b0;
        o_s_axi_rvalid <= 1'b1;
        o_s_axi_rresp <= RESP_OKAY;
        case (i_s_axi_araddr)
          REG_CTRL: o_s_axi_rdata <= {29'h0, q, run};
          REG_BANK: o_s_axi_rdata <= {28'h0, bank_select_register};
          REG_TPTR: o_s_axi_rdata <= {11'h0, table_pointer};
          REG_TLAT: o_s_axi_rdata <= {24'h0, table_latch};
          REG_PC: o_s_axi_rdata <= {11'h0, pc};
          REG_IWORD: o_s_axi_rdata <= {16'h0, exec_word};
          REG_ICOUNT: o_s_axi_rdata <= icount;
          default:
          begin
            o_s_axi_rdata <= '0;
            o_s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end
      else if (o_s_axi_rvalid && i_s_axi_rready)
        o_s_axi_rvalid <= 1'b0;
    end
  end

  assign o_pm_addr = pc;
endmodule

// *** rtl/mid_pkg.sv ***
package mid_pkg;
  // sequencer: one instruction cycle is four oscillator periods
  localparam int unsigned OSC_PER_INSTR = 4;
  typedef enum logic [1:0] {
    Q1 = 2'b00,
    Q2 = 2'b01,
    Q3 = 2'b11,
    Q4 = 2'b10
  } mid_q_t;

  // instruction classes seen by the sequencer
  typedef enum logic [3:0] {
    CLS_NOP = 4'h0,
    CLS_BYTE = 4'h1,
    CLS_BYTESKIP = 4'h2,
    CLS_BIT = 4'h3,
    CLS_BITSKIP = 4'h4,
    CLS_LIT = 4'h5,
    CLS_MOVE = 4'h6,
    CLS_GOTO = 4'h7,
    CLS_CALL = 4'h8,
    CLS_LPTR = 4'h9,
    CLS_BRA = 4'ha,
    CLS_RCALL = 4'hb,
    CLS_BCOND = 4'hc,
    CLS_RET = 4'hd,
    CLS_TBLRD = 4'he,
    CLS_TBLWR = 4'hf
  } mid_cls_t;

  localparam int unsigned PC_W = 21;
  localparam int unsigned FA_W = 12;
  localparam logic [3:0] SECOND_WORD_TAG = 4'hf;
  localparam logic [15:0] NOP_WORD = 16'h0000;
  localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
  localparam logic [PC_W-1:0] TPTR_STEP = 21'h000001;
  localparam logic [3:0] ACCESS_BANK = 4'h0;

  // pointer_step_mode encodings
  localparam logic [1:0] MM_NONE = 2'h0;
  localparam logic [1:0] MM_POST_INC = 2'h1;
  localparam logic [1:0] MM_POST_DEC = 2'h2;
  localparam logic [1:0] MM_PRE_INC = 2'h3;

  // register map, byte addresses
  localparam int unsigned AXI_AW = 8;
  localparam logic [AXI_AW-1:0] REG_CTRL = 8'h00;
  localparam logic [AXI_AW-1:0] REG_BANK = 8'h04;
  localparam logic [AXI_AW-1:0] REG_TPTR = 8'h08;
  localparam logic [AXI_AW-1:0] REG_TLAT = 8'h0c;
  localparam logic [AXI_AW-1:0] REG_PC = 8'h10;
  localparam logic [AXI_AW-1:0] REG_IWORD = 8'h14;
  localparam logic [AXI_AW-1:0] REG_ICOUNT = 8'h18;
  localparam int unsigned CTRL_RUN_BIT = 0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** verif/mid_instr_seq_asserts.sv ***
`timescale 1ns/1ns
module mid_instr_seq_asserts (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  // sequencer outputs
  input wire logic o_file_rd,
  input wire logic o_file_wr,
  input wire logic o_to_working_register,
  input wire logic o_lit_valid,
  input wire logic o_tbl_rd,
  input wire logic o_tbl_wr,
  input wire logic o_stack_push,
  input wire logic o_stack_pop,
  input wire logic o_shadow_save,
  input wire logic o_shadow_restore,
  // write response
  input wire logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic [1:0] o_s_axi_bresp
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_arst_n);
  a_rd_spacing: assert property (o_file_rd |=> !o_file_rd [*3])
    else $error("file read pulses closer than one instruction cycle");
  a_read_first: assert property (o_file_wr |-> $past(o_file_rd, 2) || $past(o_file_rd, 6))
    else $error("file write without a preceding read");
  a_dest_working_register: assert property (o_to_working_register |->
    !o_file_wr && ($past(o_file_rd, 2) || $past(o_lit_valid, 2)))
    else $error("working register result badly timed");
  a_lit_spacing: assert property (o_lit_valid |=> !o_lit_valid [*3])
    else $error("literal strobe repeated too soon");
  a_tbl_single: assert property (o_tbl_rd |-> !o_tbl_wr ##1 !o_tbl_rd [*3])
    else $error("table access pulses overlap");
  a_call_spacing: assert property (o_stack_push |-> !o_stack_pop ##1 !o_stack_push [*7])
    else $error("call shorter than two instruction cycles");
  a_save_fast: assert property (o_shadow_save |-> o_stack_push)
    else $error("shadow save without a call");
  a_restore_fast: assert property (o_shadow_restore |-> o_stack_pop)
    else $error("shadow restore without a return");
  a_bresp_hold: assert property (o_s_axi_bvalid && !i_s_axi_bready |=>
    o_s_axi_bvalid && $stable(o_s_axi_bresp))
    else $error("write response dropped before taken");
endmodule
bind mid_instr_seq mid_instr_seq_asserts chk_u (.i_sys_clk, .i_arst_n, .o_file_rd, .o_file_wr,
  .o_to_working_register, .o_lit_valid, .o_tbl_rd, .o_tbl_wr, .o_stack_push, .o_stack_pop, .o_shadow_save,
  .o_shadow_restore, .o_s_axi_bvalid, .i_s_axi_bready, .o_s_axi_bresp);

// *** verif/mid_pmem_model.sv ***
`timescale 1ns/1ns
module mid_pmem_model
  import mid_pkg::*;
(
  // program memory read port
  input wire logic [PC_W-1:0] i_addr,
  output logic [15:0] o_word
);
  // small array, aliases every 512 bytes; untouched words read as no-op
  logic [15:0] mem [0:255];
  initial
  begin
    foreach (mem[i])
      mem[i] = NOP_WORD;
  end
  // word-aligned fetch: bit 0 of the byte address is ignored
  assign o_word = mem[i_addr[8:1]];
endmodule

// *** verif/tb.sv ***
`timescale 1ns/1ns
module tb;
  import mid_pkg::*;
  logic i_sys_clk = 1'b0, i_arst_n = 1'b0, i_cond_true = 1'b1;
  logic [AXI_AW-1:0] i_s_axi_awaddr = '0, i_s_axi_araddr = '0;
  logic i_s_axi_awvalid = 0, i_s_axi_wvalid = 0, i_s_axi_bready = 0;
  logic i_s_axi_arvalid = 0, i_s_axi_rready = 0;
  logic [31:0] i_s_axi_wdata = '0, o_s_axi_rdata;
  logic [3:0] i_s_axi_wstrb = 4'hf;
  logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
  logic [1:0] o_s_axi_bresp, o_s_axi_rresp;
  logic [PC_W-1:0] o_pm_addr, o_ret_addr, o_tbl_addr, max_pc = '0;
  // return lands on the looping branch at 0x0e
  logic [PC_W-1:0] i_tos = 21'h00000e;
  logic [15:0] i_pm_word;
  logic [7:0] i_tbl_rdata = 8'ha5, o_tbl_wdata;
  logic o_stack_push, o_stack_pop, o_shadow_save, o_shadow_restore, o_bit_op;
  logic o_file_rd, o_file_wr, o_to_working_register, o_lit_valid, o_tbl_rd, o_tbl_wr;
  logic [FA_W-1:0] o_file_addr;
  logic [2:0] o_bit_idx;
  logic [19:0] o_literal;
  int bad_count = 0, samples_checked = 0, cyc = 0, t0;
  int rd_t[$], wr_t[$];
  logic [FA_W-1:0] rd_a[$], wr_a[$];
  int working_register_t = -1, lit_t = -1, tbl_t = -1, push_t = -1, pop_t = -1;
  logic [31:0] lit_v, tbl_a, ret_a, bit_v;
  logic sh_sv = 0, sh_rs = 0;
  logic [15:0] prog_lo[9] = '{16'h2755, 16'h2422, 16'h8b44, 16'h0e7f, 16'h0009, 16'hed40,
    16'hf000, 16'hd7ff, 16'h2688};
  logic [15:0] prog_hi[6] = '{16'h6244, 16'h2633, 16'hf3aa, 16'h2666, 16'h0013, 16'h2699};
  int exp_rd_t[5] = '{0, 4, 8, 28, 40};
  logic [FA_W-1:0] exp_rd_a[5] = '{12'h355, 12'h022, 12'h344, 12'h044, 12'h066};
  int exp_wr_t[3] = '{2, 10, 42};
  logic [FA_W-1:0] exp_wr_a[3] = '{12'h355, 12'h344, 12'h066};

  mid_instr_seq dut_u (.i_sys_clk, .i_arst_n, .i_s_axi_awaddr, .i_s_axi_awvalid, .o_s_axi_awready,
    .i_s_axi_wdata, .i_s_axi_wstrb, .i_s_axi_wvalid, .o_s_axi_wready, .o_s_axi_bresp,
    .o_s_axi_bvalid, .i_s_axi_bready, .i_s_axi_araddr, .i_s_axi_arvalid, .o_s_axi_arready,
    .o_s_axi_rdata, .o_s_axi_rresp, .o_s_axi_rvalid, .i_s_axi_rready, .o_pm_addr, .i_pm_word,
    .i_cond_true, .i_tos, .o_stack_push, .o_stack_pop, .o_ret_addr, .o_shadow_save,
    .o_shadow_restore, .o_file_addr, .o_file_rd, .o_file_wr, .o_to_working_register, .o_bit_op, .o_bit_idx,
    .o_literal, .o_lit_valid, .o_tbl_addr, .o_tbl_rd, .o_tbl_wr, .o_tbl_wdata, .i_tbl_rdata);
  mid_pmem_model pm_u (.i_addr(o_pm_addr), .o_word(i_pm_word));

  always #25 i_sys_clk = ~i_sys_clk;

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic axi_wr(input logic [AXI_AW-1:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge i_sys_clk);
    i_s_axi_awaddr <= a;
    i_s_axi_awvalid <= 1'b1;
    i_s_axi_wdata <= d;
    i_s_axi_wvalid <= 1'b1;
    i_s_axi_bready <= 1'b1;
    forever
    begin
      @(posedge i_sys_clk);
      if (o_s_axi_awready === 1'b1) i_s_axi_awvalid <= 1'b0;
      if (o_s_axi_wready === 1'b1) i_s_axi_wvalid <= 1'b0;
      if (o_s_axi_bvalid === 1'b1)
      begin
        i_s_axi_bready <= 1'b0;
        chk("bresp", {30'h0, er}, {30'h0, o_s_axi_bresp});
        break;
      end
    end
  endtask

  task automatic axi_rd(input logic [AXI_AW-1:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge i_sys_clk);
    i_s_axi_araddr <= a;
    i_s_axi_arvalid <= 1'b1;
    i_s_axi_rready <= 1'b1;
    forever
    begin
      @(posedge i_sys_clk);
      if (o_s_axi_arready === 1'b1) i_s_axi_arvalid <= 1'b0;
      if (o_s_axi_rvalid === 1'b1)
      begin
        i_s_axi_rready <= 1'b0;
        chk("rdata", e, o_s_axi_rdata);
        chk("rresp", {30'h0, er}, {30'h0, o_s_axi_rresp});
        break;
      end
    end
  endtask

  // event log; times are clock counts, compared relative to the first file read
  always @(posedge i_sys_clk)
  begin
    if (o_file_rd === 1'b1)
    begin
      rd_t.push_back(cyc);
      rd_a.push_back(o_file_addr);
      if (o_bit_op === 1'b1) bit_v = {29'h0, o_bit_idx};
    end
    if (o_file_wr === 1'b1)
    begin
      wr_t.push_back(cyc);
      wr_a.push_back(o_file_addr);
    end
    // keep the first pulse only: later literal and call strobes reuse these outputs
    if (o_to_working_register === 1'b1 && working_register_t < 0) working_register_t = cyc;
    if (o_lit_valid === 1'b1 && lit_t < 0) {lit_t, lit_v} = {cyc, 12'h0, o_literal};
    if (o_tbl_rd === 1'b1) {tbl_t, tbl_a} = {cyc, 11'h0, o_tbl_addr};
    if (o_stack_push === 1'b1) {push_t, ret_a, sh_sv} = {cyc, 11'h0, o_ret_addr, o_shadow_save};
    if (o_stack_pop === 1'b1) {pop_t, sh_rs} = {cyc, o_shadow_restore};
    if (i_arst_n && o_pm_addr > max_pc) max_pc = o_pm_addr;
    cyc++;
  end

  initial
  begin
    #(50 * 3000);
    bad_count++;
    $display("ERROR watchdog expected finish seen hang");
    wrap_up();
  end

  initial
  begin
    // load after time zero so the model's own fill cannot overwrite the program
    repeat (12) @(posedge i_sys_clk);
    foreach (prog_lo[i]) pm_u.mem[i] = prog_lo[i];
    foreach (prog_hi[i]) pm_u.mem[64 + i] = prog_hi[i];
    i_arst_n <= 1'b1;
    axi_rd(8'h1c, 32'h0, RESP_SLVERR);
    axi_wr(8'h20, 32'h1, RESP_SLVERR);
    axi_wr(REG_BANK, 32'h3, RESP_OKAY);
    axi_wr(REG_TPTR, 32'h1234, RESP_OKAY);
    axi_rd(REG_BANK, 32'h3, RESP_OKAY);
    axi_wr(REG_CTRL, 32'h1, RESP_OKAY);
    // enough for the whole program to reach the branch loop
    repeat (150) @(posedge i_sys_clk);
    axi_wr(REG_CTRL, 32'h0, RESP_OKAY);
    chk("rd count", 32'd5, rd_t.size());
    chk("wr count", 32'd3, wr_t.size());
    if (rd_t.size() == 5 && wr_t.size() == 3)
    begin
      t0 = rd_t[0];
      foreach (exp_rd_a[i])
      begin
        chk("rd addr", exp_rd_a[i], rd_a[i]);
        chk("rd time", exp_rd_t[i], rd_t[i] - t0);
      end
      foreach (exp_wr_a[i])
      begin
        chk("wr addr", exp_wr_a[i], wr_a[i]);
        chk("wr time", exp_wr_t[i], wr_t[i] - t0);
      end
      chk("working_register time", 32'd6, working_register_t - t0);
      chk("lit time", 32'd12, lit_t - t0);
      chk("tbl time", 32'd18, tbl_t - t0);
      chk("push time", 32'd21, push_t - t0);
      chk("pop time", 32'd45, pop_t - t0);
    end
    chk("bit index", 32'd5, bit_v);
    chk("literal", 32'h7f, lit_v);
    chk("tbl addr", 32'h1234, tbl_a);
    chk("ret addr", 32'he, ret_a);
    chk("shadow", 32'h3, {30'h0, sh_sv, sh_rs});
    chk("pc bound", 32'h1, {31'h0, max_pc < 21'h90});
    axi_rd(REG_TPTR, 32'h1235, RESP_OKAY);
    axi_rd(REG_TLAT, 32'ha5, RESP_OKAY);
    wrap_up();
  end
endmodule
